// ---- rtl/mmd_decoder.sv ----
/*
 * Memory-space decoder: steers program fetches to flash, alternate SRAM or the
 * external bus; data moves to on-chip SRAM or the bus; and scratchpad/special
 * register accesses by addressing mode. Holds the 256-byte scratchpad.
 * Assumes one request at a time from the core, issued while ready_out is high.
 */
`timescale 1ns/1ps
`default_nettype none
module mmd_decoder (
  input wire logic mclk_in, // processor clock
  input wire logic reset_in, // sync reset, high
  input wire logic external_access_n_in, // low forces off-chip fetch
  input wire logic timed_access_in, // protected write window open
  input wire logic page_mode_in, // page mode 1 selected
  input wire logic fetch_req_in, // program fetch request
  input wire logic [15:0] fetch_addr_in, // program address
  input wire logic xmove_req_in, // external data move request
  input wire logic xmove_wr_in, // store, else load
  input wire logic xmove_via_pointer_in, // pointer form, else register
  input wire logic [2:0] xmove_reg_in, // working register index
  input wire logic [7:0] xmove_wdata_in, // store data
  input wire logic iram_req_in, // scratchpad or register access
  input wire logic [1:0] iram_mode_in, // direct, indirect, wreg, bit
  input wire logic iram_wr_in, // write, else read
  input wire logic [7:0] iram_addr_in, // address, index or bit
  input wire logic [7:0] iram_wdata_in, // write data, bit in lsb
  input wire logic stack_push_in, // push iram_wdata_in
  input wire logic stack_pop_in, // pop to iram_rdata_out
  input wire logic [7:0] p0_in, // port 0 pins in
  output logic ready_out, // request may be taken
  output logic stall_out, // core waits on bus
  output logic flash_sel_out, // flash fetch pulse
  output logic sram_sel_out, // on-chip SRAM access pulse
  output logic sram_wr_out, // SRAM write qualifier
  output logic [15:0] mem_addr_out, // on-chip memory address
  output logic [7:0] mem_wdata_out, // SRAM write data
  output logic [7:0] iram_rdata_out, // scratchpad/register read data
  output logic iram_valid_out, // read data valid pulse
  output logic ext_done_out, // external cycle done pulse
  output logic [7:0] ext_rdata_out, // external read data
  output logic [7:0] p0_out, // port 0 drive value
  output logic p0_oe_n_out, // port 0 enable, low drives
  output logic [7:0] p2_out, // port 2 pins
  output logic ale_out, // address latch strobe
  output logic program_strobe_n_out, // external fetch strobe
  output logic rd_n_out, // external read strobe
  output logic wr_n_out // external write strobe
);
  // ==========================================
  // state
  logic [7:0] scratch_q [0:255];
  logic [7:0] stack_ptr_q, ptr0_lo_q, ptr0_hi_q, ptr1_lo_q, ptr1_hi_q;
  logic [7:0] ptr_sel_q, port2_q, status_word_q, iram_rdata_q;
  logic [2:0] size_q;
  logic program_ram_enable_q, iram_valid_q;
  logic flash_sel_q, sram_sel_q, sram_wr_q;
  logic [15:0] mem_addr_q;
  logic [7:0] mem_wdata_q;
  logic ext_busy, ext_stall, ext_start;
  logic [7:0] bus_p2;
  mmd_pkg::mmd_kind_e ext_kind;
  logic [15:0] ext_addr;

  // ==========================================
  // request arbitration
  assign ready_out = !ext_busy;
  wire fetch_go = fetch_req_in && ready_out;
  wire xmove_go = xmove_req_in && ready_out && !fetch_req_in;
  wire iram_go = iram_req_in && ready_out;

  // ==========================================
  // program window
  // size code to top address
  wire [15:0] size_top = (size_q == mmd_pkg::SIZE_1K) ? mmd_pkg::TOP_1K :
                         (size_q == mmd_pkg::SIZE_2K) ? mmd_pkg::TOP_2K :
                         (size_q == mmd_pkg::SIZE_4K) ? mmd_pkg::TOP_4K :
                         (size_q == mmd_pkg::SIZE_8K) ? mmd_pkg::TOP_8K : mmd_pkg::TOP_16K;
  wire fetch_flash = external_access_n_in && (size_q != mmd_pkg::SIZE_NONE) &&
                     (fetch_addr_in <= size_top);
  wire fetch_sram = external_access_n_in && program_ram_enable_q &&
                    (fetch_addr_in >= mmd_pkg::ALT_PROG_LO) &&
                    (fetch_addr_in <= mmd_pkg::ALT_PROG_HI);
  wire fetch_ext = !fetch_flash && !fetch_sram;

  // ==========================================
  // external data move address
  // bank from status word bits
  wire [1:0] bank = {status_word_q[mmd_pkg::BANK_HI_POS], status_word_q[mmd_pkg::BANK_LO_POS]};
  wire [7:0] xmove_reg_addr = {3'h0, bank, xmove_reg_in};
  wire ptr_sel = ptr_sel_q[mmd_pkg::PTR_SEL_POS];
  // pointer form picks one of two
  wire [15:0] ptr_addr = ptr_sel ? {ptr1_hi_q, ptr1_lo_q} : {ptr0_hi_q, ptr0_lo_q};
  // register form uses port 2 latch
  wire [15:0] xmove_addr = xmove_via_pointer_in ? ptr_addr :
                           {port2_q, scratch_q[xmove_reg_addr]};
  // beyond on-chip data goes to bus
  wire xmove_int = (xmove_addr <= mmd_pkg::DATA_TOP);

  // fetch and data move stay distinct kinds
  assign ext_start = (fetch_go && fetch_ext) || (xmove_go && !xmove_int);
  assign ext_kind = fetch_go ? mmd_pkg::KIND_FETCH :
                    xmove_wr_in ? mmd_pkg::KIND_WRITE : mmd_pkg::KIND_READ;
  assign ext_addr = fetch_go ? fetch_addr_in : xmove_addr;

  // ==========================================
  // scratchpad addressing
  wire [7:0] wreg_addr = {3'h0, bank, iram_addr_in[2:0]};
  wire [7:0] bit_byte = iram_addr_in[7] ? {iram_addr_in[7:3], 3'h0} :
                        (mmd_pkg::BIT_AREA_BASE | {4'h0, iram_addr_in[6:3]});
  wire [7:0] eff_addr = (iram_mode_in == mmd_pkg::MODE_WREG) ? wreg_addr :
                        (iram_mode_in == mmd_pkg::MODE_BIT) ? bit_byte : iram_addr_in;
  wire is_sfr = eff_addr[7] && (iram_mode_in != mmd_pkg::MODE_INDIRECT) &&
                (iram_mode_in != mmd_pkg::MODE_WREG);
  wire [7:0] size_rd = {mmd_pkg::SIZE_UPPER_ONES, program_ram_enable_q, size_q};
  wire [7:0] sfr_rd = (eff_addr == mmd_pkg::SFR_STACK_PTR) ? stack_ptr_q :
                      (eff_addr == mmd_pkg::SFR_PTR0_LO) ? ptr0_lo_q :
                      (eff_addr == mmd_pkg::SFR_PTR0_HI) ? ptr0_hi_q :
                      (eff_addr == mmd_pkg::SFR_PTR1_LO) ? ptr1_lo_q :
                      (eff_addr == mmd_pkg::SFR_PTR1_HI) ? ptr1_hi_q :
                      (eff_addr == mmd_pkg::SFR_PTR_SEL) ? ptr_sel_q :
                      (eff_addr == mmd_pkg::SFR_PORT2) ? port2_q :
                      (eff_addr == mmd_pkg::SFR_SIZE_SEL) ? size_rd :
                      (eff_addr == mmd_pkg::SFR_STATUS_WORD) ? status_word_q : 8'h00;
  wire [7:0] byte_rd = is_sfr ? sfr_rd : scratch_q[eff_addr];
  wire is_bit = (iram_mode_in == mmd_pkg::MODE_BIT);
  wire [7:0] bit_mask = 8'h01 << iram_addr_in[2:0];
  wire [7:0] bit_merged = iram_wdata_in[0] ? (byte_rd | bit_mask) : (byte_rd & ~bit_mask);
  wire [7:0] wbyte = is_bit ? bit_merged : iram_wdata_in;
  wire [7:0] rbyte = is_bit ? {7'h00, |(byte_rd & bit_mask)} : byte_rd;
  wire sfr_wr = iram_go && iram_wr_in && is_sfr;
  wire ram_wr = iram_go && iram_wr_in && !is_sfr;
  wire [7:0] sp_inc = stack_ptr_q + 8'h01;
  wire size_wr = sfr_wr && (eff_addr == mmd_pkg::SFR_SIZE_SEL);
  wire size_code_valid = (wbyte[2:0] <= mmd_pkg::SIZE_16K);

  // ==========================================
  // scratchpad array
  // push writes above pointer
  always_ff @(posedge mclk_in) begin
    if (stack_push_in) begin
      scratch_q[sp_inc] <= iram_wdata_in;
    end else if (ram_wr) begin
      scratch_q[eff_addr] <= wbyte;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      iram_rdata_q <= 8'h00;
      iram_valid_q <= 1'b0;
    end else begin
      iram_valid_q <= stack_pop_in || (iram_go && !iram_wr_in);
      if (stack_pop_in) iram_rdata_q <= scratch_q[stack_ptr_q];
      else if (iram_go && !iram_wr_in) iram_rdata_q <= rbyte;
    end
  end

  // ==========================================
  // special registers
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      stack_ptr_q <= mmd_pkg::RST_STACK_PTR;
      ptr0_lo_q <= 8'h00;
      ptr0_hi_q <= 8'h00;
      ptr1_lo_q <= 8'h00;
      ptr1_hi_q <= 8'h00;
      ptr_sel_q <= mmd_pkg::RST_PTR_SEL;
      port2_q <= mmd_pkg::RST_PORT2;
      status_word_q <= mmd_pkg::RST_STATUS_WORD;
    end else begin
      if (stack_push_in) stack_ptr_q <= sp_inc;
      else if (stack_pop_in) stack_ptr_q <= stack_ptr_q - 8'h01;
      else if (sfr_wr && eff_addr == mmd_pkg::SFR_STACK_PTR) stack_ptr_q <= wbyte;
      if (sfr_wr && eff_addr == mmd_pkg::SFR_PTR0_LO) ptr0_lo_q <= wbyte;
      if (sfr_wr && eff_addr == mmd_pkg::SFR_PTR0_HI) ptr0_hi_q <= wbyte;
      if (sfr_wr && eff_addr == mmd_pkg::SFR_PTR1_LO) ptr1_lo_q <= wbyte;
      if (sfr_wr && eff_addr == mmd_pkg::SFR_PTR1_HI) ptr1_hi_q <= wbyte;
      if (sfr_wr && eff_addr == mmd_pkg::SFR_PTR_SEL) ptr_sel_q <= wbyte;
      if (sfr_wr && eff_addr == mmd_pkg::SFR_PORT2) port2_q <= wbyte;
      if (sfr_wr && eff_addr == mmd_pkg::SFR_STATUS_WORD) status_word_q <= wbyte;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      size_q <= mmd_pkg::RST_SIZE_CODE;
      program_ram_enable_q <= 1'b0;
    end else if (size_wr && timed_access_in) begin
      program_ram_enable_q <= wbyte[mmd_pkg::PRAM_EN_POS];
      if (size_code_valid) size_q <= wbyte[2:0];
    end
  end

  // ==========================================
  // on-chip memory selects
  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      flash_sel_q <= 1'b0;
      sram_sel_q <= 1'b0;
      sram_wr_q <= 1'b0;
      mem_addr_q <= 16'h0000;
      mem_wdata_q <= 8'h00;
    end else begin
      flash_sel_q <= fetch_go && fetch_flash && !fetch_sram;
      sram_sel_q <= (fetch_go && fetch_sram) || (xmove_go && xmove_int);
      sram_wr_q <= xmove_go && xmove_int && xmove_wr_in;
      if (fetch_go) mem_addr_q <= fetch_addr_in;
      else if (xmove_go) mem_addr_q <= xmove_addr;
      if (xmove_go) mem_wdata_q <= xmove_wdata_in;
    end
  end

  // ==========================================
  // external bus
  mmd_ext_cycle u_bus (
    .mclk_in(mclk_in),
    .reset_in(reset_in),
    .start_in(ext_start),
    .kind_in(ext_kind),
    .addr_in(ext_addr),
    .wdata_in(xmove_wdata_in),
    .page_mode_in(page_mode_in),
    .p0_in(p0_in),
    .p0_out(p0_out),
    .p0_oe_n_out(p0_oe_n_out),
    .p2_out(bus_p2),
    .ale_out(ale_out),
    .program_strobe_n_out(program_strobe_n_out),
    .rd_n_out(rd_n_out),
    .wr_n_out(wr_n_out),
    .busy_out(ext_busy),
    .stall_out(ext_stall),
    .done_out(ext_done_out),
    .rdata_out(ext_rdata_out)
  );

  // port 2 is bus while cycle runs
  assign p2_out = ext_busy ? bus_p2 : port2_q;
  assign stall_out = ext_stall;
  assign flash_sel_out = flash_sel_q;
  assign sram_sel_out = sram_sel_q;
  assign sram_wr_out = sram_wr_q;
  assign mem_addr_out = mem_addr_q;
  assign mem_wdata_out = mem_wdata_q;
  assign iram_rdata_out = iram_rdata_q;
  assign iram_valid_out = iram_valid_q;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  a_flash_full_window: assert property (fetch_go && external_access_n_in && !program_ram_enable_q && size_q == mmd_pkg::SIZE_16K && fetch_addr_in <= 16'h3FFF |=> flash_sel_out && !sram_sel_out)
    else $error("fetch inside 16k window not sent to flash");
  a_fetch_over_limit: assert property (fetch_go && size_q == mmd_pkg::SIZE_4K && !program_ram_enable_q && fetch_addr_in > 16'h0FFF |=> !flash_sel_out ##1 !program_strobe_n_out)
    else $error("fetch above limit not taken off-chip");
  a_size_after_reset: assert property ($past(reset_in) |-> size_q == mmd_pkg::RST_SIZE_CODE)
    else $error("size field not full window after reset");
  a_size_write_locked: assert property (size_wr && !timed_access_in |=> $stable(size_q) && $stable(program_ram_enable_q))
    else $error("unprotected write changed size field");
  a_size_applies_next: assert property (
    size_wr && timed_access_in && iram_wdata_in[2:0] == mmd_pkg::SIZE_NONE ##[1:2]
    fetch_go && external_access_n_in && !program_ram_enable_q |=> !flash_sel_out)
    else $error("new size not in effect on next fetch");
  a_reserved_size_kept: assert property (size_wr && timed_access_in && wbyte[2:0] > 3'h5 |=> $stable(size_q))
    else $error("reserved size code accepted");
  a_access_pin_forces: assert property (fetch_go && !external_access_n_in |=> !flash_sel_out && !sram_sel_out && ale_out ##1 !program_strobe_n_out)
    else $error("fetch with access pin low stayed on-chip");
  a_xdata_load_strobe: assert property (xmove_go && !xmove_wr_in && !xmove_int && !page_mode_in |=> ale_out ##1 !rd_n_out [*3] ##1 rd_n_out && wr_n_out)
    else $error("external load strobe wrong");
  a_bank_select_read: assert property (iram_go && !iram_wr_in && iram_mode_in == mmd_pkg::MODE_WREG && !stack_pop_in |=> iram_valid_out && iram_rdata_out == scratch_q[{3'h0, $past(bank), $past(iram_addr_in[2:0])}])
    else $error("working register read from wrong bank");
endmodule : mmd_decoder
`default_nettype wire

// ---- rtl/mmd_pkg.sv ----
/*
 * Constants for the memory-space decoder: special register addresses, field positions,
 * reset values, program window limits and bus cycle encodings.
 * Assumes one processor clock; no other block shares these names.
 */
package mmd_pkg;
  // ==========================================
  // special register addresses (direct space)
  localparam logic [7:0] SFR_STACK_PTR = 8'h81;
  localparam logic [7:0] SFR_PTR0_LO = 8'h82;
  localparam logic [7:0] SFR_PTR0_HI = 8'h83;
  localparam logic [7:0] SFR_PTR1_LO = 8'h84;
  localparam logic [7:0] SFR_PTR1_HI = 8'h85;
  localparam logic [7:0] SFR_PTR_SEL = 8'h86;
  localparam logic [7:0] SFR_PORT2 = 8'hA0;
  localparam logic [7:0] SFR_SIZE_SEL = 8'hC2;
  localparam logic [7:0] SFR_STATUS_WORD = 8'hD0;
  // ==========================================
  // reset values and size register upper read bits
  localparam logic [7:0] RST_STACK_PTR = 8'h07;
  localparam logic [7:0] RST_PTR_SEL = 8'h04;
  localparam logic [7:0] RST_PORT2 = 8'hFF;
  localparam logic [7:0] RST_STATUS_WORD = 8'h00;
  localparam logic [2:0] RST_SIZE_CODE = 3'h5;
  localparam logic [3:0] SIZE_UPPER_ONES = 4'hF;
  // ==========================================
  // field positions
  localparam int BANK_HI_POS = 4;
  localparam int BANK_LO_POS = 3;
  localparam int PRAM_EN_POS = 3;
  localparam int PTR_SEL_POS = 0;
  // ==========================================
  // program size codes and window tops
  localparam logic [2:0] SIZE_NONE = 3'h0;
  localparam logic [2:0] SIZE_1K = 3'h1;
  localparam logic [2:0] SIZE_2K = 3'h2;
  localparam logic [2:0] SIZE_4K = 3'h3;
  localparam logic [2:0] SIZE_8K = 3'h4;
  localparam logic [2:0] SIZE_16K = 3'h5;
  localparam logic [15:0] TOP_1K = 16'h03FF;
  localparam logic [15:0] TOP_2K = 16'h07FF;
  localparam logic [15:0] TOP_4K = 16'h0FFF;
  localparam logic [15:0] TOP_8K = 16'h1FFF;
  localparam logic [15:0] TOP_16K = 16'h3FFF;
  localparam logic [15:0] ALT_PROG_LO = 16'h0400;
  localparam logic [15:0] ALT_PROG_HI = 16'h07FF;
  localparam logic [15:0] DATA_TOP = 16'h03FF;
  localparam logic [7:0] BIT_AREA_BASE = 8'h20;
  // ==========================================
  // scratchpad access modes
  localparam logic [1:0] MODE_DIRECT = 2'h0;
  localparam logic [1:0] MODE_INDIRECT = 2'h1;
  localparam logic [1:0] MODE_WREG = 2'h2;
  localparam logic [1:0] MODE_BIT = 2'h3;
  // ==========================================
  // external bus cycle without a page hit: four clocks, three stalled
  localparam int EXT_CYCLE_CLOCKS = 4;
  typedef enum logic [4:0] {
    PH_IDLE = 5'h01,
    PH_ADDR = 5'h02,
    PH_STR1 = 5'h04,
    PH_STR2 = 5'h08,
    PH_LAST = 5'h10
  } mmd_phase_e;
  typedef enum logic [2:0] {
    KIND_FETCH = 3'h1,
    KIND_READ = 3'h2,
    KIND_WRITE = 3'h4
  } mmd_kind_e;
endpackage : mmd_pkg

// ---- rtl/mmd_ext_cycle.sv ----
/*
 * External multiplexed bus cycle: address phase with latch strobe, then
 * three strobe clocks; page mode on a high-byte hit skips the address phase and the first two strobe clocks.
 * Assumes one cycle at a time; start only while busy_out is low.
 */
`timescale 1ns/1ps
`default_nettype none
module mmd_ext_cycle (
  input wire logic mclk_in, // processor clock
  input wire logic reset_in, // sync reset, high
  input wire logic start_in, // begin a bus cycle
  input wire mmd_pkg::mmd_kind_e kind_in, // fetch, read or write
  input wire logic [15:0] addr_in, // cycle address
  input wire logic [7:0] wdata_in, // store data
  input wire logic page_mode_in, // page mode 1 on
  input wire logic [7:0] p0_in, // port 0 pins in
  output logic [7:0] p0_out, // port 0 drive value
  output logic p0_oe_n_out, // port 0 enable, low drives
  output logic [7:0] p2_out, // high address byte
  output logic ale_out, // address latch strobe
  output logic program_strobe_n_out, // external fetch strobe
  output logic rd_n_out, // external read strobe
  output logic wr_n_out, // external write strobe
  output logic busy_out, // cycle in progress
  output logic stall_out, // processor must wait
  output logic done_out, // cycle finished pulse
  output logic [7:0] rdata_out // captured read data
);
  mmd_pkg::mmd_phase_e state_q, state_d;
  mmd_pkg::mmd_kind_e kind_q;
  logic [15:0] addr_q;
  logic [7:0] wdata_q, rdata_q, page_hi_q;
  logic done_q, page_vld_q;
  wire page_hit = page_mode_in && page_vld_q && (addr_in[15:8] == page_hi_q);
  wire strobe_ph = state_q inside {mmd_pkg::PH_STR1, mmd_pkg::PH_STR2, mmd_pkg::PH_LAST};

  // ==========================================
  // phase sequence
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      mmd_pkg::PH_IDLE: if (start_in) state_d = page_hit ? mmd_pkg::PH_LAST : mmd_pkg::PH_ADDR;
      mmd_pkg::PH_ADDR: state_d = mmd_pkg::PH_STR1;
      mmd_pkg::PH_STR1: state_d = mmd_pkg::PH_STR2;
      mmd_pkg::PH_STR2: state_d = mmd_pkg::PH_LAST;
      mmd_pkg::PH_LAST: state_d = mmd_pkg::PH_IDLE;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      state_q <= mmd_pkg::PH_IDLE;
      kind_q <= mmd_pkg::KIND_FETCH;
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
      page_hi_q <= 8'h00;
      page_vld_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (start_in && state_q == mmd_pkg::PH_IDLE) begin
        kind_q <= kind_in;
        addr_q <= addr_in;
        wdata_q <= wdata_in;
        page_hi_q <= addr_in[15:8];
        page_vld_q <= page_mode_in;
      end
    end
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      rdata_q <= 8'h00;
      done_q <= 1'b0;
    end else begin
      done_q <= (state_q == mmd_pkg::PH_LAST);
      if (state_q == mmd_pkg::PH_LAST && kind_q != mmd_pkg::KIND_WRITE) rdata_q <= p0_in;
    end
  end

  // ==========================================
  // pin drive
  // port 0 muxed address/data, port 2 high
  assign p0_out = (state_q == mmd_pkg::PH_ADDR) ? addr_q[7:0] : wdata_q;
  assign p0_oe_n_out = !((state_q == mmd_pkg::PH_ADDR) ||
                         (strobe_ph && kind_q == mmd_pkg::KIND_WRITE));
  assign p2_out = addr_q[15:8];
  assign ale_out = (state_q == mmd_pkg::PH_ADDR);
  assign program_strobe_n_out = !(strobe_ph && kind_q == mmd_pkg::KIND_FETCH);
  assign rd_n_out = !(strobe_ph && kind_q == mmd_pkg::KIND_READ);
  assign wr_n_out = !(strobe_ph && kind_q == mmd_pkg::KIND_WRITE);
  assign busy_out = (state_q != mmd_pkg::PH_IDLE);
  assign stall_out = state_q inside {mmd_pkg::PH_ADDR, mmd_pkg::PH_STR1, mmd_pkg::PH_STR2};
  assign done_out = done_q;
  assign rdata_out = rdata_q;

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  a_stall_three_clocks: assert property (start_in && !busy_out && !page_hit |=> stall_out [*3] ##1 !stall_out ##1 done_out)
    else $error("full bus cycle stall count wrong");
  a_page_hit_nostall: assert property (start_in && !busy_out && page_hit |=> !stall_out && !ale_out ##1 done_out)
    else $error("page hit stalled");
  a_fetch_strobe_low: assert property (start_in && !busy_out && !page_hit && kind_in == mmd_pkg::KIND_FETCH |=> program_strobe_n_out && ale_out ##1 !program_strobe_n_out [*3] ##1 program_strobe_n_out)
    else $error("fetch strobe not low for three clocks");
endmodule : mmd_ext_cycle
`default_nettype wire

// ---- verif/mmd_ext_mem.sv ----
/* external program/data memory on the multiplexed bus.
   assumes ale, strobes and ports of the decoder, one clock */
`timescale 1ns/1ps
`default_nettype none
module mmd_ext_mem (
  input wire logic mclk_in, // processor clock
  input wire logic ale_in, // address latch strobe
  input wire logic program_strobe_n_in, // fetch strobe
  input wire logic rd_n_in, // read strobe
  input wire logic [7:0] p0_in, // port 0 from decoder
  input wire logic [7:0] p2_in, // high address byte
  output logic [7:0] p0_out // port 0 reply
);
  // ==========================================
  // latch address, reply while strobed
  logic [15:0] addr_q = 16'h0000;
  logic [7:0] last_q = 8'h00;
  logic drive;
  // low byte latched from port 0
  always_ff @(posedge mclk_in) if (ale_in) addr_q <= {p2_in, p0_in};
  assign drive = !program_strobe_n_in || !rd_n_in;
  assign p0_out = drive ? (addr_q[7:0] ^ addr_q[15:8] ^ 8'h5a) : ~last_q;
  always_ff @(posedge mclk_in) if (drive) last_q <= p0_out;
endmodule : mmd_ext_mem
`default_nettype wire

// ---- verif/tb_mmd_decoder.sv ----
/* self-checking bench for the memory-space decoder.
   assumes the external memory model answers fetches and loads */
`timescale 1ns/1ps
`default_nettype none
module tb_mmd_decoder;
  logic mclk_in = 0, reset_in = 1, ext_n = 1, ta = 0, freq = 0, xreq = 0, ireq = 0, iwr = 0;
  logic xwr = 0, ssel;
  logic [15:0] fa = 16'h0000;
  logic [1:0] im = 2'h0;
  logic [7:0] ia = 8'h00, iwd = 8'h00, xwd = 8'h00, p0_dec, p0_mem, p0_pin, p2;
  logic oe_n, ale, ps_n, rd_n, flash, ivalid, edone, ready;
  logic [7:0] irdata, erdata;
  logic [9:0] notes[$];
  logic [9:0] got;
  logic [31:0] rs = 32'h2f8a_ba23, r;
  logic [15:0] tops [6] = '{16'h0000, 16'h0400, 16'h0800, 16'h1000, 16'h2000, 16'h4000};
  int fail_count = 0, check_count = 0, cyc = 0;
  initial forever #2 mclk_in = ~mclk_in;
  assign p0_pin = oe_n ? p0_mem : p0_dec;
  mmd_decoder i_mmd_decoder (.mclk_in(mclk_in), .reset_in(reset_in),
    .external_access_n_in(ext_n), .timed_access_in(ta), .page_mode_in(1'b0),
    .fetch_req_in(freq), .fetch_addr_in(fa), .xmove_req_in(xreq), .xmove_wr_in(xwr),
    .xmove_via_pointer_in(1'b1), .xmove_reg_in(3'h0), .xmove_wdata_in(xwd),
    .iram_req_in(ireq), .iram_mode_in(im), .iram_wr_in(iwr), .iram_addr_in(ia),
    .iram_wdata_in(iwd), .stack_push_in(1'b0), .stack_pop_in(1'b0), .p0_in(p0_pin),
    .ready_out(ready), .stall_out(), .flash_sel_out(flash), .sram_sel_out(ssel),
    .sram_wr_out(), .mem_addr_out(), .mem_wdata_out(), .iram_rdata_out(irdata),
    .iram_valid_out(ivalid), .ext_done_out(edone), .ext_rdata_out(erdata),
    .p0_out(p0_dec), .p0_oe_n_out(oe_n), .p2_out(p2), .ale_out(ale),
    .program_strobe_n_out(ps_n), .rd_n_out(rd_n), .wr_n_out());
  mmd_ext_mem i_mmd_ext_mem (.mclk_in(mclk_in), .ale_in(ale), .program_strobe_n_in(ps_n),
    .rd_n_in(rd_n), .p0_in(p0_dec), .p2_in(p2), .p0_out(p0_mem));
  // ==========================================
  // helpers
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction : rnd
  task automatic chk(input logic [9:0] g, input logic [9:0] e);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic close_out();
    fail_count += notes.size();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : close_out
  task automatic wait_ready();
    int n = 0;
    @(negedge mclk_in);
    while (ready !== 1'b1 && n < 20) begin
      @(negedge mclk_in);
      n++;
    end
  endtask : wait_ready
  task automatic fetch(input logic [15:0] a, input logic [1:0] x);
    freq = 1;
    fa = a;
    notes.push_back(x[0] ? {2'b01, a[7:0] ^ a[15:8] ^ 8'h5a} : {x[1], x[1], 8'h00});
    @(negedge mclk_in);
    freq = 0;
    wait_ready();
  endtask : fetch
  task automatic reg_io(input logic [1:0] m, input logic w, t, input logic [7:0] a, d, e);
    ireq = 1;
    im = m;
    iwr = w;
    ta = t;
    ia = a;
    iwd = d;
    if (!w) notes.push_back({2'b10, e});
    @(negedge mclk_in);
    ireq = 0;
    ta = 0;
    @(negedge mclk_in);
  endtask : reg_io
  // ==========================================
  // result watcher and timeout
  always @(negedge mclk_in) if (!reset_in && (flash || ssel || edone || ivalid)) begin
    got = flash ? 10'h000 : ssel ? 10'h300 : edone ? {2'b01, erdata} : {2'b10, irdata};
    chk(got, notes.size() ? notes.pop_front() : 10'h3ff);
  end
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      close_out();
    end
  end
  // ==========================================
  // tests
  initial begin
    repeat (12) @(negedge mclk_in);
    reset_in = 0;
    reg_io(0, 0, 0, 8'hC2, 0, 8'hF5);
    reg_io(0, 0, 0, 8'hD0, 0, 8'h00);
    fetch(16'h3FFF, 0);
    repeat (4) begin
      r = rnd();
      fetch({2'b01, r[13:0]}, 1);
    end
    reg_io(0, 1, 0, 8'hC2, 8'h00, 0);
    reg_io(0, 0, 0, 8'hC2, 0, 8'hF5);
    $display("test window done");
    for (int c = 0; c < 6; c++) begin
      reg_io(0, 1, 1, 8'hC2, c[7:0], 0);
      if (c > 0) fetch(tops[c] - 16'h0001, 0);
      fetch(tops[c], 1);
    end
    reg_io(0, 1, 1, 8'hC2, 8'h06, 0);
    reg_io(0, 0, 0, 8'hC2, 0, 8'hF5);
    reg_io(0, 1, 1, 8'hC2, 8'h0D, 0);
    fetch(16'h0400, 2);
    fetch(16'h03FF, 0);
    ext_n = 0;
    fetch(16'h0000, 1);
    ext_n = 1;
    $display("test size done");
    r = rnd();
    reg_io(1, 1, 0, 8'h90, r[7:0], 0);
    reg_io(1, 0, 0, 8'h90, 0, r[7:0]);
    reg_io(0, 0, 0, 8'h90, 0, 8'h00);
    reg_io(0, 1, 0, 8'hD0, 8'h10, 0);
    reg_io(1, 1, 0, 8'h13, r[15:8], 0);
    reg_io(2, 0, 0, 8'h03, 0, r[15:8]);
    reg_io(1, 1, 0, 8'h21, 8'h04, 0);
    reg_io(3, 0, 0, 8'h0A, 0, 8'h01);
    reg_io(0, 1, 0, 8'h84, 8'h34, 0);
    reg_io(0, 1, 0, 8'h85, 8'h12, 0);
    reg_io(0, 1, 0, 8'h86, 8'h05, 0);
    // load, then store: read data holds across the store
    for (int w = 0; w < 2; w++) begin
      xreq = 1;
      xwr = w[0];
      xwd = r[15:8];
      notes.push_back({2'b01, 8'h12 ^ 8'h34 ^ 8'h5a});
      @(negedge mclk_in);
      xreq = 0;
      wait_ready();
    end
    repeat (4) @(negedge mclk_in);
    $display("test data done");
    close_out();
  end
endmodule : tb_mmd_decoder
`default_nettype wire
